// >>> lpi_pkg.sv
package lpi_pkg;

    // ------------------------------------------------------------
    // Control line codes
    // ------------------------------------------------------------
    localparam logic [1:0] LPI_CTL_IDLE    = 2'h0;
    localparam logic [1:0] LPI_CTL_STATUS  = 2'h1;
    localparam logic [1:0] LPI_CTL_RECEIVE = 2'h2;
    localparam logic [1:0] LPI_CTL_GRANT   = 2'h3;
    localparam logic [1:0] LPI_CTL_HOLD    = 2'h1;
    localparam logic [1:0] LPI_CTL_TX      = 2'h2;

    // ------------------------------------------------------------
    // Request types and lengths
    // ------------------------------------------------------------
    localparam logic [2:0] LPI_REQ_IMM   = 3'h0;
    localparam logic [2:0] LPI_REQ_FAIR  = 3'h3;
    localparam logic [2:0] LPI_REQ_READ  = 3'h4;
    localparam logic [2:0] LPI_REQ_WRITE = 3'h5;
    localparam logic [4:0] LPI_LEN_ARB   = 5'h0B;
    localparam logic [4:0] LPI_LEN_READ  = 5'h09;
    localparam logic [4:0] LPI_LEN_WRITE = 5'h11;
    localparam logic [4:0] LPI_LEN_TYPE  = 5'h04;

    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int LPI_ST_ARB_GAP  = 0;
    localparam int LPI_ST_SUB_GAP  = 1;
    localparam int LPI_ST_BUS_RST  = 2;
    localparam int LPI_ST_ADDR_LSB = 4;
    localparam int LPI_ST_DATA_LSB = 8;
    localparam logic [2:0] LPI_ST_LAST_SHORT = 3'h1;
    localparam logic [2:0] LPI_ST_LAST_FULL  = 3'h7;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    localparam int         LPI_NREGS    = 16;
    localparam logic [3:0] LPI_REG_GAP  = 4'h0;
    localparam logic [3:0] LPI_REG_STAT = 4'h1;
    localparam logic [7:0] LPI_GAP_RST  = 8'h04;
    localparam logic [7:0] LPI_REG_RST  = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] rtype;
        logic [1:0] speed;
        logic [3:0] prio;
        logic [3:0] addr;
        logic [7:0] data;
    } lpi_req_t;

    typedef struct packed {
        logic [1:0] speed;
        logic [3:0] prio;
    } lpi_arb_t;

    typedef enum logic [6:0] {
        LPI_S_IDLE    = 7'h01,
        LPI_S_RECEIVE = 7'h02,
        LPI_S_STATUS  = 7'h04,
        LPI_S_GRANT   = 7'h08,
        LPI_S_GR_IDLE = 7'h10,
        LPI_S_LINK    = 7'h20,
        LPI_S_TURN    = 7'h40
    } lpi_state_t;

endpackage : lpi_pkg

// >>> lpi_req_rx.sv
`timescale 1ns/100ps
`default_nettype none
module lpi_req_rx
    import lpi_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     resetn,
    input  wire logic     link_request_line,
    output var  logic     req_valid,
    output var  lpi_req_t req
);

    logic        busy_r;
    logic [4:0]  cnt_r;
    logic [15:0] sh_r;
    logic [2:0]  type_r;
    logic [4:0]  len;
    logic [15:0] sh_nxt;

    // ------------------------------------------------------------
    // Length from request type
    // ------------------------------------------------------------
    always_comb begin
        sh_nxt = {sh_r[14:0], link_request_line};
        case (type_r)
            LPI_REQ_READ:  len = LPI_LEN_READ;
            LPI_REQ_WRITE: len = LPI_LEN_WRITE;
            default:       len = LPI_LEN_ARB;
        endcase
    end

    // ------------------------------------------------------------
    // Serial capture
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_r    <= 1'b0;
            cnt_r     <= 5'h00;
            sh_r      <= 16'h0000;
            type_r    <= 3'h0;
            req_valid <= 1'b0;
            req       <= '0;
        end else begin
            req_valid <= 1'b0;
            if (!busy_r) begin
                if (link_request_line) begin
                    busy_r <= 1'b1;
                    cnt_r  <= 5'h01;
                    sh_r   <= 16'h0000;
                end
            end else begin
                sh_r  <= sh_nxt;
                cnt_r <= cnt_r + 5'h01;
                if (cnt_r == LPI_LEN_TYPE - 5'h01) begin
                    type_r <= sh_nxt[2:0];
                end
                if (cnt_r >= LPI_LEN_TYPE && cnt_r == len - 5'h01) begin
                    busy_r    <= 1'b0;
                    req_valid <= 1'b1;
                    req.rtype <= type_r;
                    req.speed <= '0;
                    req.prio  <= '0;
                    req.addr  <= '0;
                    req.data  <= '0;
                    case (type_r)
                        LPI_REQ_WRITE: begin
                            req.addr <= sh_nxt[12:9];
                            req.data <= sh_nxt[8:1];
                        end
                        LPI_REQ_READ: begin
                            req.addr <= sh_nxt[4:1];
                        end
                        default: begin
                            req.speed <= sh_nxt[6:5];
                            req.prio  <= sh_nxt[4:1];
                        end
                    endcase
                end
            end
        end
    end

endmodule : lpi_req_rx
`default_nettype wire

// >>> lpi_phy_link.sv
// Functional notes
// - Drop fair request while driving receive
// - Pending immediate request granted at packet end
// - One arbitration request pending; extras ignored
// - Read request answered by retried full status
// - Write loads register when request completes
// - Status starts from idle, holds code 01
// - Arriving packet suspends status transfer
// - One idle cycle between status transfers; this design idles two cycles
// - Short status normally; full only for reads
// - Status bits: gaps, bus reset, reserved
// - Full status carries address and data
// - Grant: transmit one cycle, then idle
// - Link hold keeps serial bus data-on
// - Hold after packet: gap, regrant, same speed
// - Idle resumes one clock after second idle
// - Request type encodings
// - Arbitration request eleven bits with priority
// - Write seventeen bits, read nine bits
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module lpi_phy_link
    import lpi_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       link_request_line,
    input  wire logic [1:0] ctl_in,
    output var  logic [1:0] interface_control_lines,
    output var  logic       ctl_oe,
    input  wire logic [1:0] d_in,
    output var  logic [1:0] d_out,
    output var  logic       d_oe,
    input  wire logic       rx_pkt_active,
    input  wire logic [1:0] rx_pkt_data,
    input  wire logic       arb_won,
    output var  logic       arb_req,
    output var  lpi_arb_t   arb_info,
    output var  logic       bus_data_on,
    output var  logic       tx_valid,
    output var  logic [1:0] tx_data,
    input  wire logic       ev_arb_reset_gap,
    input  wire logic       ev_subaction_gap,
    input  wire logic       ev_bus_reset,
    input  wire logic [3:0] sw_addr,
    input  wire logic [7:0] sw_wdata,
    input  wire logic       sw_wr,
    input  wire logic       sw_rd,
    output var  logic [7:0] sw_rdata
);

    lpi_state_t  state_r;
    lpi_state_t  state_nxt;
    logic        req_valid;
    lpi_req_t    req;
    logic        imm_pend_r;
    logic        rd_pend_r;
    logic [3:0]  rd_addr_r;
    logic [2:0]  flags_r;
    logic        idle_prev_r;
    logic [15:0] stat_word_r;
    logic [2:0]  stat_idx_r;
    logic [2:0]  stat_last_r;
    logic [15:0] new_word;
    logic [2:0]  new_last;
    logic        idle_cnt_r;
    logic        saw_tx_r;
    logic [7:0]  hold_cnt_r;
    logic [7:0]  regs_r [LPI_NREGS];
    logic [7:0]  stat_live;
    logic        grant_go;
    logic        stat_go;
    logic        stat_done;
    logic        regrant;
    logic        lk_wr;
    logic        is_arb_req;

    // ------------------------------------------------------------
    // Request deserializer
    // ------------------------------------------------------------
    lpi_req_rx u_req_rx (
        .ref_clk           (ref_clk),
        .resetn            (resetn),
        .link_request_line (link_request_line),
        .req_valid         (req_valid),
        .req               (req)
    );

    // ------------------------------------------------------------
    // Decisions
    // ------------------------------------------------------------
    always_comb begin
        is_arb_req = req_valid && (req.rtype == LPI_REQ_IMM || req.rtype == LPI_REQ_FAIR);
        lk_wr      = req_valid && req.rtype == LPI_REQ_WRITE;
        grant_go   = imm_pend_r || (arb_req && arb_won);
        stat_go    = idle_prev_r && (flags_r != 3'h0 || rd_pend_r);
        stat_done  = state_r == LPI_S_STATUS && !rx_pkt_active && stat_idx_r == stat_last_r;
        regrant    = saw_tx_r && ctl_in == LPI_CTL_HOLD && hold_cnt_r >= regs_r[LPI_REG_GAP];
        stat_live  = {4'h0, saw_tx_r, rd_pend_r, imm_pend_r, arb_req};
        new_word   = 16'h0000;
        new_word[LPI_ST_ARB_GAP] = flags_r[0];
        new_word[LPI_ST_SUB_GAP] = flags_r[1];
        new_word[LPI_ST_BUS_RST] = flags_r[2];
        new_last   = LPI_ST_LAST_SHORT;
        if (rd_pend_r) begin
            new_word[LPI_ST_ADDR_LSB +: 4] = rd_addr_r;
            new_word[LPI_ST_DATA_LSB +: 8] = (rd_addr_r == LPI_REG_STAT) ? stat_live
                                                                          : regs_r[rd_addr_r];
            new_last = LPI_ST_LAST_FULL;
        end
    end

    // ------------------------------------------------------------
    // Interface state machine
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LPI_S_IDLE: begin
                if (rx_pkt_active) begin
                    state_nxt = LPI_S_RECEIVE;
                end else if (grant_go) begin
                    state_nxt = LPI_S_GRANT;
                end else if (stat_go) begin
                    state_nxt = LPI_S_STATUS;
                end
            end
            LPI_S_RECEIVE: begin
                if (!rx_pkt_active) begin
                    state_nxt = imm_pend_r ? LPI_S_GRANT : LPI_S_IDLE;
                end
            end
            LPI_S_STATUS: begin
                if (rx_pkt_active) begin
                    state_nxt = LPI_S_RECEIVE;
                end else if (stat_done) begin
                    state_nxt = LPI_S_IDLE;
                end
            end
            LPI_S_GRANT:   state_nxt = LPI_S_GR_IDLE;
            LPI_S_GR_IDLE: state_nxt = LPI_S_LINK;
            LPI_S_LINK: begin
                if (idle_cnt_r && ctl_in == LPI_CTL_IDLE) begin
                    state_nxt = LPI_S_TURN;
                end else if (regrant) begin
                    state_nxt = LPI_S_GRANT;
                end
            end
            LPI_S_TURN:    state_nxt = LPI_S_IDLE;
            default:       state_nxt = LPI_S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r     <= LPI_S_IDLE;
            idle_prev_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            idle_prev_r <= state_r == LPI_S_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Control and data line drivers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            interface_control_lines <= LPI_CTL_IDLE;
            ctl_oe                  <= 1'b1;
            d_out                   <= 2'h0;
            d_oe                    <= 1'b1;
        end else begin
            ctl_oe <= !(state_nxt == LPI_S_LINK || state_nxt == LPI_S_TURN);
            d_oe   <= !(state_nxt == LPI_S_LINK || state_nxt == LPI_S_TURN);
            d_out  <= 2'h0;
            case (state_nxt)
                LPI_S_RECEIVE: begin
                    interface_control_lines <= LPI_CTL_RECEIVE;
                    d_out                   <= rx_pkt_data;
                end
                LPI_S_STATUS: begin
                    interface_control_lines <= LPI_CTL_STATUS;
                    d_out <= (state_r == LPI_S_STATUS) ? stat_word_r[3:2] : new_word[1:0];
                end
                LPI_S_GRANT:   interface_control_lines <= LPI_CTL_GRANT;
                default:       interface_control_lines <= LPI_CTL_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status transfer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stat_word_r <= 16'h0000;
            stat_idx_r  <= 3'h0;
            stat_last_r <= 3'h0;
        end else if (state_nxt == LPI_S_STATUS && state_r != LPI_S_STATUS) begin
            stat_word_r <= new_word;
            stat_idx_r  <= 3'h0;
            stat_last_r <= new_last;
        end else if (state_r == LPI_S_STATUS) begin
            stat_word_r <= {2'h0, stat_word_r[15:2]};
            stat_idx_r  <= stat_idx_r + 3'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            flags_r <= 3'h0;
        end else begin
            // New events win over the clear of a completed transfer
            flags_r <= (stat_done ? 3'h0 : flags_r)
                       | {ev_bus_reset, ev_subaction_gap, ev_arb_reset_gap};
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_pend_r <= 1'b0;
            rd_addr_r <= 4'h0;
        end else if (req_valid && req.rtype == LPI_REQ_READ) begin
            rd_pend_r <= 1'b1;
            rd_addr_r <= req.addr;
        end else if (stat_done && stat_last_r == LPI_ST_LAST_FULL) begin
            rd_pend_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Arbitration requests
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            arb_req    <= 1'b0;
            imm_pend_r <= 1'b0;
            arb_info   <= '0;
        end else if (is_arb_req && !arb_req && !imm_pend_r) begin
            if (req.rtype == LPI_REQ_IMM) begin
                imm_pend_r <= 1'b1;
                arb_info   <= {req.speed, req.prio};
            end else if (state_r != LPI_S_RECEIVE && state_nxt != LPI_S_RECEIVE) begin
                arb_req  <= 1'b1;
                arb_info <= {req.speed, req.prio};
            end
        end else if (state_nxt == LPI_S_GRANT && state_r != LPI_S_LINK) begin
            arb_req    <= 1'b0;
            imm_pend_r <= 1'b0;
        end else if (state_nxt == LPI_S_RECEIVE && state_r != LPI_S_RECEIVE) begin
            arb_req <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Link ownership
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            idle_cnt_r  <= 1'b0;
            saw_tx_r    <= 1'b0;
            hold_cnt_r  <= 8'h00;
            bus_data_on <= 1'b0;
            tx_valid    <= 1'b0;
            tx_data     <= 2'h0;
        end else begin
            bus_data_on <= state_r == LPI_S_LINK && ctl_in == LPI_CTL_HOLD;
            tx_valid    <= state_r == LPI_S_LINK && ctl_in == LPI_CTL_TX;
            tx_data     <= (state_r == LPI_S_LINK && ctl_in == LPI_CTL_TX) ? d_in : 2'h0;
            idle_cnt_r  <= state_r == LPI_S_LINK && ctl_in == LPI_CTL_IDLE;
            if (state_r != LPI_S_LINK || regrant) begin
                saw_tx_r   <= 1'b0;
                hold_cnt_r <= 8'h00;
            end else if (ctl_in == LPI_CTL_TX) begin
                saw_tx_r   <= 1'b1;
                hold_cnt_r <= 8'h00;
            end else if (saw_tx_r && ctl_in == LPI_CTL_HOLD && hold_cnt_r != 8'hFF) begin
                hold_cnt_r <= hold_cnt_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < LPI_NREGS; g++) begin : g_reg
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    regs_r[g] <= (4'(g) == LPI_REG_GAP) ? LPI_GAP_RST : LPI_REG_RST;
                end else if (4'(g) == LPI_REG_STAT) begin
                    regs_r[g] <= LPI_REG_RST;
                end else if (lk_wr && req.addr == 4'(g)) begin
                    regs_r[g] <= req.data;
                end else if (sw_wr && sw_addr == 4'(g)) begin
                    regs_r[g] <= sw_wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sw_rdata <= 8'h00;
        end else if (sw_rd) begin
            sw_rdata <= (sw_addr == LPI_REG_STAT) ? stat_live : regs_r[sw_addr];
        end else begin
            sw_rdata <= 8'h00;
        end
    end

endmodule : lpi_phy_link
`default_nettype wire

// >>> lpi_phy_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lpi_phy_link_properties
    import lpi_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic [1:0] ctl_in,
    input wire logic [1:0] interface_control_lines,
    input wire logic       ctl_oe,
    input wire logic       d_oe,
    input wire logic [1:0] d_in,
    input wire logic [1:0] d_out,
    input wire logic       rx_pkt_active,
    input wire logic [1:0] rx_pkt_data,
    input wire logic       bus_data_on,
    input wire logic       tx_valid,
    input wire logic [1:0] tx_data,
    input wire logic       sw_rd,
    input wire logic [7:0] sw_rdata
);
    // ----------
    // Sequences
    // ----------
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    wire logic st;
    wire logic idl;
    assign st  = ctl_oe && (interface_control_lines == LPI_CTL_STATUS);
    assign idl = ctl_oe && d_oe && (interface_control_lines == LPI_CTL_IDLE);
    sequence s_grant;
        ctl_oe && (interface_control_lines == LPI_CTL_GRANT);
    endsequence
    sequence s_two_idle;
        (!ctl_oe && (ctl_in == LPI_CTL_IDLE)) [*2];
    endsequence
    // ----------
    // Properties
    // ----------
    a_grant_idle: assert property (s_grant |=> idl ##1 !(ctl_oe || d_oe))
        else $error("grant not followed by idle then release");
    a_status_entry: assert property ($rose(st) |-> $past(idl))
        else $error("status started without idle before it");
    a_rx_suspend: assert property (st && rx_pkt_active |=>
        ctl_oe && (interface_control_lines == LPI_CTL_RECEIVE))
        else $error("status not suspended by packet");
    a_rx_data: assert property (ctl_oe &&
        (interface_control_lines == LPI_CTL_RECEIVE) |-> d_out == $past(rx_pkt_data))
        else $error("receive data not forwarded");
    a_hold_dataon: assert property (!ctl_oe && (ctl_in == LPI_CTL_HOLD)
        |=> bus_data_on)
        else $error("hold did not keep data-on");
    a_tx_forward: assert property (!ctl_oe && (ctl_in == LPI_CTL_TX)
        |=> tx_valid && (tx_data == $past(d_in)))
        else $error("transmit data not forwarded");
    a_release_turn: assert property (s_two_idle |=> !ctl_oe ##1 idl)
        else $error("no turnaround after second idle");
    a_rdata_zero: assert property (!$past(sw_rd) |-> sw_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule : lpi_phy_link_properties
bind lpi_phy_link lpi_phy_link_properties u_props (
    .ref_clk(ref_clk), .resetn(resetn), .ctl_in(ctl_in), .d_in(d_in),
    .interface_control_lines(interface_control_lines), .ctl_oe(ctl_oe),
    .d_out(d_out), .d_oe(d_oe), .rx_pkt_active(rx_pkt_active), .rx_pkt_data(rx_pkt_data),
    .bus_data_on(bus_data_on), .tx_valid(tx_valid), .tx_data(tx_data),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata));
`default_nettype wire

// >>> lpi_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module lpi_link_model
    import lpi_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [1:0] interface_control_lines,
    input  wire logic       ctl_oe,
    input  wire logic [1:0] d_out,
    input  wire logic       tx_valid,
    output var  logic       link_request_line,
    output var  logic [1:0] ctl_in,
    output var  logic [1:0] d_in
);
    logic [3:0]  cnt;
    logic        tog;
    logic        st_prev;
    logic        st_done;
    logic [3:0]  st_len;
    logic [15:0] st_q;
    logic [7:0]  gr_n;
    logic [7:0]  tx_n;
    wire  logic  st;
    assign st = ctl_oe && (interface_control_lines == LPI_CTL_STATUS);
    // ----------
    // Ownership
    // ----------
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 4'h0; tog <= 1'b0; gr_n <= 8'h00; tx_n <= 8'h00;
        end else begin
            tog <= ~tog;
            if (ctl_oe && (interface_control_lines == LPI_CTL_GRANT)) begin
                cnt  <= 4'h1;
                gr_n <= gr_n + 8'h01;
            end else if (cnt != 4'h0) begin
                cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
            end
            if (tx_valid) tx_n <= tx_n + 8'h01;
        end
    end
    always_comb begin
        ctl_in = 2'h3;
        d_in   = {tog, tog};
        if (cnt == 4'h2 || cnt == 4'h3) ctl_in = LPI_CTL_HOLD;
        if (cnt == 4'h4 || cnt == 4'h5) begin
            ctl_in = LPI_CTL_TX;
            d_in   = (cnt == 4'h4) ? 2'h1 : 2'h2;
        end
        if (cnt == 4'h6 || cnt == 4'h7) ctl_in = LPI_CTL_IDLE;
    end
    // ----------
    // Status capture
    // ----------
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_prev <= 1'b0; st_done <= 1'b0; st_len <= 4'h0; st_q <= 16'h0000;
        end else begin
            st_prev <= st;
            st_done <= st_prev && !st;
            if (st) begin
                st_q   <= {d_out, st_q[15:2]};
                st_len <= st_prev ? st_len + 4'h1 : 4'h1;
            end
        end
    end
    // ----------
    // Serial request
    // ----------
    task automatic send(input logic [16:0] v, input int n, input logic wi);
        int i;
        for (i = 0; wi && i < 500 && !(ctl_oe && interface_control_lines == LPI_CTL_IDLE); i++)
            @(posedge ref_clk);
        if (wi) @(posedge ref_clk);
        for (i = n - 1; i >= 0; i--) begin
            @(posedge ref_clk);
            link_request_line <= v[i];
        end
        @(posedge ref_clk);
        link_request_line <= 1'b0;
    endtask : send
    initial link_request_line = 1'b0;
endmodule : lpi_link_model
`default_nettype wire

// >>> test_lpi_phy_link.sv
`timescale 1ns/100ps
`default_nettype none
module test_lpi_phy_link;
    import lpi_pkg::*;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       rx = 1'b0;
    logic [1:0] rxd = 2'h0;
    logic       arb_won = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [3:0] sw_addr = 4'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic       sw_wr = 1'b0;
    logic       sw_rd = 1'b0;
    wire  logic lrq, ctl_oe, d_oe, arb_req, bdo, txv;
    wire  logic [1:0] ctl_in, ctl, d_in, d_out, txd;
    wire  logic [7:0] sw_rdata;
    wire  lpi_arb_t   arb_info;
    int mismatches = 0;
    int comparisons = 0;
    int i;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) rxd <= rxd + 2'h1;
    lpi_phy_link uut (.ref_clk(ref_clk), .resetn(resetn), .link_request_line(lrq),
        .ctl_in(ctl_in), .interface_control_lines(ctl), .ctl_oe(ctl_oe), .d_in(d_in),
        .d_out(d_out), .d_oe(d_oe), .rx_pkt_active(rx), .rx_pkt_data(rxd),
        .arb_won(arb_won), .arb_req(arb_req), .arb_info(arb_info), .bus_data_on(bdo),
        .tx_valid(txv), .tx_data(txd), .ev_arb_reset_gap(ev[0]), .ev_subaction_gap(ev[1]),
        .ev_bus_reset(ev[2]), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    lpi_link_model m (.ref_clk(ref_clk), .resetn(resetn), .interface_control_lines(ctl),
        .ctl_oe(ctl_oe), .d_out(d_out), .tx_valid(txv), .link_request_line(lrq),
        .ctl_in(ctl_in), .d_in(d_in));
    // ----------
    // Tasks
    // ----------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sw_wr <= 1'b1; sw_addr <= a; sw_wdata <= d;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask : sw_write
    task automatic sw_read(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        sw_rd <= 1'b1; sw_addr <= a;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        #1 chk("sw_rdata", {8'h00, e}, {8'h00, sw_rdata});
    endtask : sw_read
    task automatic wait_stat(input logic [3:0] n, input logic [15:0] e);
        for (int k = 0; k < 400; k++) begin
            @(posedge ref_clk);
            #1;
            if (m.st_done) break;
        end
        chk("status length", {12'h000, n}, {12'h000, m.st_len});
        chk("status word", e, (n == 4'h2) ? {12'h000, m.st_q[15:12]} : m.st_q);
    endtask : wait_stat
    task automatic wait_grants(input logic [7:0] n);
        for (int k = 0; k < 200 && m.gr_n != n; k++) @(posedge ref_clk);
        repeat (16) @(posedge ref_clk);
        chk("grants", {8'h00, n}, {8'h00, m.gr_n});
    endtask : wait_grants
    task automatic results;
        if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        #300000;
        mismatches++;
        results();
    end
    // ----------
    // Tests
    // ----------
    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        #1 chk("reset ctl", 16'h000C, {12'h0, d_oe, ctl_oe, ctl});
        sw_read(LPI_REG_GAP, LPI_GAP_RST);
        sw_write(4'h2, 8'hA5);
        sw_write(LPI_REG_STAT, 8'hFF);
        sw_read(4'h2, 8'hA5);
        sw_read(LPI_REG_STAT, 8'h00);
        m.send(17'h1A6B4, 17, 1'b1);
        repeat (3) @(posedge ref_clk);
        sw_read(4'h3, 8'h5A);
        m.send(17'h00186, 9, 1'b1);
        wait_stat(4'h8, 16'h5A30);
        for (i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            ev <= 3'h1 << i;
            @(posedge ref_clk);
            ev <= 3'h0;
            wait_stat(4'h2, 16'h0001 << i);
        end
        m.send(17'h00186, 9, 1'b1);
        for (i = 0; i < 100 && !(ctl_oe && ctl == LPI_CTL_STATUS); i++) @(posedge ref_clk);
        @(posedge ref_clk);
        rx <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rx <= 1'b0;
        wait_stat(4'h8, 16'h5A30);
        m.send(17'h005AA, 11, 1'b1);
        @(posedge ref_clk);
        #1 chk("arb_req", 16'h0001, {15'h0, arb_req});
        chk("arb_info", 16'h0015, {10'h0, arb_info});
        m.send(17'h00400, 11, 1'b1);
        arb_won <= 1'b1;
        wait_grants(8'h01);
        arb_won <= 1'b0;
        chk("tx count", 16'h0002, {8'h00, m.tx_n});
        chk("arb_req", 16'h0000, {15'h0, arb_req});
        m.send(17'h00580, 11, 1'b1);
        rx <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rx <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 chk("arb_req dropped", 16'h0000, {15'h0, arb_req});
        @(posedge ref_clk);
        rx <= 1'b1;
        m.send(17'h00400, 11, 1'b0);
        @(posedge ref_clk);
        rx <= 1'b0;
        wait_grants(8'h02);
        m.send(17'h00580, 11, 1'b1);
        arb_won <= 1'b1;
        wait_grants(8'h03);
        arb_won <= 1'b0;
        chk("tx count", 16'h0006, {8'h00, m.tx_n});
        results();
    end
endmodule : test_lpi_phy_link
`default_nettype wire
